// ===== design/emce_exec.sv
// Executer for the computed call, the two indexed moves and frame pointer add-and-return
// How it works
// - Call pushes PC plus two first
// - Call then loads PC low from working register
// - Then high/upper latches copied into PC
// - Call takes two cycles, second idle
// - Call leaves working, status, bank registers alone
// - Direct move source is frame pointer plus offset
// - Direct move destination is 12-bit literal
// - Both moves reach full 4096-byte space
// - Direct move refuses PC low, stack-top bytes
// - Indirect-register source reads as zero
// - Indexed move encoding, second word prefix 1111
// - Indexed move addresses are frame pointer plus offsets
// - Indexed move refuses PC low, stack-top bytes
// - Indirect-register indexed destination makes move nop
// - Add literal to frame pointer, then return
`timescale 1ns/1ns
module emce_exec
    import emce_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              ref_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              clk_en_i,
    // Instruction stream
    input  wire logic              instr_valid_i,
    input  wire logic [WORD_W-1:0] instr_word_i,
    // Core state
    input  wire logic [PC_W-1:0]   pc_i,
    input  wire logic [DATA_W-1:0] working_register_i,
    input  wire logic [DATA_W-1:0] pc_high_latch_i,
    input  wire logic [DATA_W-1:0] pc_upper_latch_i,
    input  wire logic [ADDR_W-1:0] frame_pointer_reg_i,
    input  wire logic [PC_W-1:0]   return_stack_top_i,
    // Data memory read data
    input  wire logic [DATA_W-1:0] rd_data_i,
    // Cycle status
    output logic      [1:0]        phase_o,
    output logic                   busy_o,
    // Return stack
    output logic                   stack_push_o,
    output logic      [PC_W-1:0]   stack_push_data_o,
    output logic                   stack_pop_o,
    // Program counter load
    output logic                   pc_load_o,
    output logic      [PC_W-1:0]   pc_load_value_o,
    // Frame pointer load
    output logic                   fp_load_o,
    output logic      [ADDR_W-1:0] fp_value_o,
    // Data memory
    output logic                   mem_rd_o,
    output logic      [ADDR_W-1:0] mem_rd_addr_o,
    output logic                   mem_wr_o,
    output logic      [ADDR_W-1:0] mem_wr_addr_o,
    output logic      [DATA_W-1:0] mem_wr_data_o,
    output logic                   illegal_dest_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CALL_EXEC,
        ST_MOVE_READ,
        ST_RET_EXEC,
        ST_MOVE_WRITE,
        ST_NOP_CYCLE
    } emce_state_e;

    emce_state_e       st_q;
    logic [1:0]        q_q;
    logic [WORD_W-1:0] word1_q;
    logic [WORD_W-1:0] word2_q;
    logic              second_ok_q;
    logic              is_mvss_q;
    logic              src_ind_q;
    logic [DATA_W-1:0] src_data_q;
    logic              take_first;
    logic              dec_call;
    logic              dec_move;
    logic              dec_ret;
    logic              second_phase;
    logic [OFS_W-1:0]  ag_offset;
    logic [ADDR_W-1:0] ag_addr;
    logic              ag_ind;
    logic              ag_banned;

    // ************************************************************
    // Decode of the first word
    // ************************************************************
    // Words starting 1111 match no opcode here, so they fall through as nop
    always_comb begin
        take_first = (st_q == ST_IDLE) && (q_q == PH_Q1) && instr_valid_i;
        dec_call   = take_first && (instr_word_i == OPC_CALL_WORK);
        dec_move   = take_first && (instr_word_i[15:8] == OPC_MOVE_HI);
        dec_ret    = take_first && (instr_word_i[15:6] == OPC_ADD_RET_HI);
    end

    // ************************************************************
    // Address builder
    // ************************************************************
    // Shared adder; source offset in cycle one, destination offset in cycle two
    always_comb begin
        second_phase = (st_q == ST_MOVE_WRITE);
        ag_offset    = second_phase ? word2_q[OFS_W-1:0] : word1_q[OFS_W-1:0];
    end

    emce_addr_gen u_addr_gen (
        .frame_ptr_i   (frame_pointer_reg_i),
        .offset_i      (ag_offset),
        .direct_sel_i  (second_phase && !is_mvss_q),
        .direct_addr_i (word2_q[ADDR_W-1:0]),
        .addr_o        (ag_addr),
        .indirect_o    (ag_ind),
        .banned_o      (ag_banned)
    );

    // ************************************************************
    // Phase counter
    // ************************************************************
    // Free running Q1..Q4; one instruction cycle is four enabled clocks
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_q <= PH_Q1;
        end else if (clk_en_i) begin
            q_q <= 2'(q_q + 2'h1);
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= ST_IDLE;
        end else if (clk_en_i) begin
            case (st_q)
                ST_IDLE: begin
                    if (dec_call) begin
                        st_q <= ST_CALL_EXEC;
                    end else if (dec_move) begin
                        st_q <= ST_MOVE_READ;
                    end else if (dec_ret) begin
                        st_q <= ST_RET_EXEC;
                    end
                end
                ST_CALL_EXEC, ST_RET_EXEC: begin
                    if (q_q == PH_Q4) begin
                        st_q <= ST_NOP_CYCLE;
                    end
                end
                ST_MOVE_READ: begin
                    if (q_q == PH_Q4) begin
                        st_q <= ST_MOVE_WRITE;
                    end
                end
                ST_MOVE_WRITE, ST_NOP_CYCLE: begin
                    if (q_q == PH_Q4) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Instruction word capture
    // ************************************************************
    // A missing or wrong-prefix second word cancels the write
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            word1_q     <= '0;
            word2_q     <= '0;
            second_ok_q <= 1'b0;
            is_mvss_q   <= 1'b0;
        end else if (clk_en_i) begin
            if (take_first) begin
                word1_q   <= instr_word_i;
                is_mvss_q <= instr_word_i[MOVE_SEL_BIT];
            end
            if (st_q == ST_MOVE_WRITE && q_q == PH_Q1) begin
                word2_q     <= instr_word_i;
                second_ok_q <= instr_valid_i &&
                               (instr_word_i[15:12] == OPC_SECOND_PFX);
            end
        end
    end

    // ************************************************************
    // Source read
    // ************************************************************
    // Read strobe during Q4 of cycle one, data taken at the end of Q4
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_rd_o      <= 1'b0;
            mem_rd_addr_o <= '0;
            src_ind_q     <= 1'b0;
            src_data_q    <= '0;
        end else if (clk_en_i) begin
            mem_rd_o <= (st_q == ST_MOVE_READ) && (q_q == PH_Q3);
            if (st_q == ST_MOVE_READ && q_q == PH_Q3) begin
                mem_rd_addr_o <= ag_addr;
                src_ind_q     <= ag_ind;
            end
            if (st_q == ST_MOVE_READ && q_q == PH_Q4) begin
                src_data_q <= src_ind_q ? '0 : rd_data_i;
            end
        end
    end

    // ************************************************************
    // Destination write
    // ************************************************************
    // Banned targets are flagged, never written
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_wr_o       <= 1'b0;
            mem_wr_addr_o  <= '0;
            mem_wr_data_o  <= '0;
            illegal_dest_o <= 1'b0;
        end else if (clk_en_i) begin
            mem_wr_o       <= 1'b0;
            illegal_dest_o <= 1'b0;
            if (st_q == ST_MOVE_WRITE && q_q == PH_Q3 && second_ok_q) begin
                if (ag_banned) begin
                    illegal_dest_o <= 1'b1;
                end else if (!(is_mvss_q && ag_ind)) begin
                    mem_wr_o      <= 1'b1;
                    mem_wr_addr_o <= ag_addr;
                    mem_wr_data_o <= src_data_q;
                end
            end
        end
    end

    // ************************************************************
    // Return stack, program counter and frame pointer
    // ************************************************************
    // Push at Q3 then PC load at Q4 keeps the documented order
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stack_push_o      <= 1'b0;
            stack_push_data_o <= '0;
            stack_pop_o       <= 1'b0;
            pc_load_o         <= 1'b0;
            pc_load_value_o   <= '0;
            fp_load_o         <= 1'b0;
            fp_value_o        <= '0;
        end else if (clk_en_i) begin
            stack_push_o <= 1'b0;
            stack_pop_o  <= 1'b0;
            pc_load_o    <= 1'b0;
            fp_load_o    <= 1'b0;
            if (st_q == ST_CALL_EXEC && q_q == PH_Q3) begin
                stack_push_o      <= 1'b1;
                stack_push_data_o <= PC_W'(pc_i + PC_RETURN_STEP);
            end
            if (st_q == ST_CALL_EXEC && q_q == PH_Q4) begin
                pc_load_o       <= 1'b1;
                pc_load_value_o <= {pc_upper_latch_i[PC_W-17:0],
                                    pc_high_latch_i,
                                    working_register_i};
            end
            if (st_q == ST_RET_EXEC && q_q == PH_Q4) begin
                fp_load_o       <= 1'b1;
                fp_value_o      <= ADDR_W'(frame_pointer_reg_i +
                                   {{(ADDR_W-LIT_W){1'b0}}, word1_q[LIT_W-1:0]});
                pc_load_o       <= 1'b1;
                pc_load_value_o <= return_stack_top_i;
                stack_pop_o     <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_o <= PH_Q1;
            busy_o  <= 1'b0;
        end else if (clk_en_i) begin
            phase_o <= 2'(q_q + 2'h1);
            busy_o  <= (st_q != ST_IDLE) || dec_call || dec_move || dec_ret;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_call_push;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (clk_en_i && st_q == ST_CALL_EXEC && q_q == PH_Q3) |=>
            stack_push_o && stack_push_data_o == PC_W'($past(pc_i) + 21'h000002);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_call_low;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (clk_en_i && st_q == ST_CALL_EXEC && q_q == PH_Q4) |=>
            pc_load_o && pc_load_value_o[7:0] == $past(working_register_i) && !stack_push_o;
    endproperty
    a_call_low: assert property (p_call_low) else $error("call low byte wrong");

    property p_call_latch;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        stack_push_o && clk_en_i ##1 pc_load_o |->
            pc_load_value_o[15:8] == $past(pc_high_latch_i) &&
            pc_load_value_o[20:16] == $past(pc_upper_latch_i[4:0]);
    endproperty
    a_call_latch: assert property (p_call_latch) else $error("call latch copy");

    property p_call_two;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (clk_en_i && dec_call) |=> (st_q == ST_CALL_EXEC)[*3] ##1
            (st_q == ST_NOP_CYCLE && !stack_push_o && !mem_wr_o)[*4] ##1 st_q == ST_IDLE;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call not two cycles");

    property p_src_addr;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(mem_rd_o) && $past(clk_en_i) |->
            mem_rd_addr_o == fp_offset($past(frame_pointer_reg_i), word1_q[6:0]);
    endproperty
    a_src_addr: assert property (p_src_addr) else $error("source address");

    property p_dir_dest;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        mem_wr_o && !is_mvss_q |-> mem_wr_addr_o == word2_q[11:0];
    endproperty
    a_dir_dest: assert property (p_dir_dest) else $error("direct destination");

    property p_banned;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        mem_wr_o |-> !is_banned_dest(mem_wr_addr_o) && !illegal_dest_o;
    endproperty
    a_banned: assert property (p_banned) else $error("banned destination written");

    property p_ind_src;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        mem_wr_o && is_indirect(mem_rd_addr_o) |-> mem_wr_data_o == 8'h00;
    endproperty
    a_ind_src: assert property (p_ind_src) else $error("indirect source nonzero");

    property p_ind_dst;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        mem_wr_o && is_mvss_q |-> !is_indirect(mem_wr_addr_o);
    endproperty
    a_ind_dst: assert property (p_ind_dst) else $error("indirect destination written");

    property p_add_ret;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(fp_load_o) && $past(clk_en_i) |-> pc_load_o && stack_pop_o &&
            pc_load_value_o == $past(return_stack_top_i) &&
            fp_value_o == 12'($past(frame_pointer_reg_i) + {6'h00, word1_q[5:0]});
    endproperty
    a_add_ret: assert property (p_add_ret) else $error("add and return wrong");

    property p_stray;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (clk_en_i && take_first && instr_word_i[15:12] == OPC_SECOND_PFX) |=> st_q == ST_IDLE;
    endproperty
    a_stray: assert property (p_stray) else $error("stray second word acted");

    c_call:  cover property (@(posedge ref_clk_i) disable iff (!nrst_i) dec_call && clk_en_i);
    c_mvsf:  cover property (@(posedge ref_clk_i) disable iff (!nrst_i) mem_wr_o && !is_mvss_q);
    c_mvss:  cover property (@(posedge ref_clk_i) disable iff (!nrst_i) mem_wr_o && is_mvss_q);
    c_illeg: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) illegal_dest_o);

endmodule : emce_exec

// ===== design/emce_pkg.sv
// Constants, encodings and address decode helpers for the extended move/call executer
package emce_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned ADDR_W = 12;   // 4096-byte data space, 000h..FFFh
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PC_W   = 21;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned OFS_W  = 7;    // Indexed offset field
    localparam int unsigned LIT_W  = 6;    // Frame pointer add literal

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [WORD_W-1:0] OPC_CALL_WORK   = 16'h0014;
    localparam logic [7:0]        OPC_MOVE_HI     = 8'heb;
    localparam int unsigned       MOVE_SEL_BIT    = 7;     // 0: to direct, 1: to indexed
    localparam logic [9:0]        OPC_ADD_RET_HI  = 10'h3a3;
    localparam logic [3:0]        OPC_SECOND_PFX  = 4'hf;
    localparam logic [PC_W-1:0]   PC_RETURN_STEP  = 21'h000002;

    // ************************************************************
    // Instruction cycle phases
    // ************************************************************
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // ************************************************************
    // Special register addresses in the data space
    // ************************************************************
    localparam logic [ADDR_W-1:0] PC_LOW_ADDR      = 12'hff9;
    localparam logic [ADDR_W-1:0] STACK_LOW_ADDR   = 12'hffd;
    localparam logic [ADDR_W-1:0] STACK_HIGH_ADDR  = 12'hffe;
    localparam logic [ADDR_W-1:0] STACK_UPPER_ADDR = 12'hfff;
    // Three indirect register groups, each a run of five addresses
    localparam logic [ADDR_W-1:0] IND_BASE0 = 12'hfeb;
    localparam logic [ADDR_W-1:0] IND_BASE1 = 12'hfe3;
    localparam logic [ADDR_W-1:0] IND_BASE2 = 12'hfdb;
    localparam logic [ADDR_W-1:0] IND_SPAN  = 12'h005;

    // Address falls in one of the indirect register groups
    function automatic logic is_indirect(input logic [ADDR_W-1:0] a);
        is_indirect = (a >= IND_BASE0 && a < IND_BASE0 + IND_SPAN) ||
                      (a >= IND_BASE1 && a < IND_BASE1 + IND_SPAN) ||
                      (a >= IND_BASE2 && a < IND_BASE2 + IND_SPAN);
    endfunction : is_indirect

    // Program counter low byte and stack top bytes cannot be move targets
    function automatic logic is_banned_dest(input logic [ADDR_W-1:0] a);
        is_banned_dest = (a == PC_LOW_ADDR) || (a == STACK_LOW_ADDR) ||
                         (a == STACK_HIGH_ADDR) || (a == STACK_UPPER_ADDR);
    endfunction : is_banned_dest

    // Frame pointer plus zero-extended offset, wrapping in the data space
    function automatic logic [ADDR_W-1:0] fp_offset(input logic [ADDR_W-1:0] fp,
                                                    input logic [OFS_W-1:0]  ofs);
        fp_offset = ADDR_W'(fp + {{(ADDR_W-OFS_W){1'b0}}, ofs});
    endfunction : fp_offset

endpackage : emce_pkg

// ===== design/emce_addr_gen.sv
// Address builder for the indexed moves: indexed or direct address plus its flags
`timescale 1ns/1ns
module emce_addr_gen
    import emce_pkg::*;
(
    // Operands
    input  wire logic [ADDR_W-1:0] frame_ptr_i,
    input  wire logic [OFS_W-1:0]  offset_i,
    input  wire logic              direct_sel_i,
    input  wire logic [ADDR_W-1:0] direct_addr_i,
    // Result
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   indirect_o,
    output logic                   banned_o
);

    // ************************************************************
    // Address and its classification
    // ************************************************************
    // Full 12-bit result so every location is reachable
    always_comb begin
        addr_o     = direct_sel_i ? direct_addr_i : fp_offset(frame_ptr_i, offset_i);
        indirect_o = is_indirect(addr_o);
        banned_o   = is_banned_dest(addr_o);
    end

endmodule : emce_addr_gen

// ===== tb/emce_exec_bench.sv
// Self-checking bench for the extended move/call executer
`timescale 1ns/1ns
module emce_exec_bench import emce_pkg::*;;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, clk_en_i = 1'b1, instr_valid_i = 1'b0;
    logic [WORD_W-1:0] instr_word_i = '0;
    logic [PC_W-1:0]   pc_i = '0, return_stack_top_i = '0;
    logic [DATA_W-1:0] working_register_i = '0, pc_high_latch_i = '0, pc_upper_latch_i = '0;
    logic [DATA_W-1:0] rd_data_i = '0;
    logic [ADDR_W-1:0] frame_pointer_reg_i = '0;
    logic [1:0]        phase_o;
    logic              busy_o, stack_push_o, stack_pop_o, pc_load_o, fp_load_o;
    logic              mem_rd_o, mem_wr_o, illegal_dest_o;
    logic [PC_W-1:0]   stack_push_data_o, pc_load_value_o;
    logic [ADDR_W-1:0] fp_value_o, mem_rd_addr_o, mem_wr_addr_o;
    logic [DATA_W-1:0] mem_wr_data_o;
    int                err_total = 0, n_compared = 0, cyc_cnt = 0, cy[7], ex_c[7];
    logic [20:0]       vl[7], ex_v[7];
    logic [11:0]       fp;

    emce_exec i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
        .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .pc_i(pc_i),
        .working_register_i(working_register_i), .pc_high_latch_i(pc_high_latch_i),
        .pc_upper_latch_i(pc_upper_latch_i), .frame_pointer_reg_i(frame_pointer_reg_i),
        .return_stack_top_i(return_stack_top_i), .rd_data_i(rd_data_i), .phase_o(phase_o),
        .busy_o(busy_o), .stack_push_o(stack_push_o), .stack_push_data_o(stack_push_data_o),
        .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_load_value_o(pc_load_value_o),
        .fp_load_o(fp_load_o), .fp_value_o(fp_value_o), .mem_rd_o(mem_rd_o),
        .mem_rd_addr_o(mem_rd_addr_o), .mem_wr_o(mem_wr_o), .mem_wr_addr_o(mem_wr_addr_o),
        .mem_wr_data_o(mem_wr_data_o), .illegal_dest_o(illegal_dest_o));

    // 125 MHz core clock
    always #4 ref_clk_i = ~ref_clk_i;

    // Hang guard, generous against 48 instructions of 12 clocks
    always @(posedge ref_clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic chk_val(input logic [20:0] got, input logic [20:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_cyc(input int i, input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            err_total++;
            $display("ERROR %0t pulse %0d at clock %0d expected %0d", $time, i, got, exp);
        end
    endtask : chk_cyc

    // Bench copies of the special address sets
    function automatic bit f_ind(input logic [11:0] a);
        return (a >= 12'hfeb && a <= 12'hfef) || (a >= 12'hfe3 && a <= 12'hfe7) ||
               (a >= 12'hfdb && a <= 12'hfdf);
    endfunction : f_ind
    function automatic bit f_ban(input logic [11:0] a);
        return a == 12'hff9 || a >= 12'hffd;
    endfunction : f_ban

    task automatic want(input int i, input int c, input logic [20:0] v);
        ex_c[i] = c;
        ex_v[i] = v;
    endtask : want

    // Pulses: 0 push, 1 pc load, 2 read, 3 write, 4 illegal, 5 pop, 6 fp load
    task automatic run(input logic [15:0] w1, input logic [15:0] w2, input logic b);
        cy = '{default: 0};
        vl = '{default: '0};
        @(negedge ref_clk_i);
        while (phase_o !== PH_Q1) @(negedge ref_clk_i);
        instr_valid_i = 1'b1;
        instr_word_i  = w1;
        for (int c = 1; c <= 9; c++) begin
            @(negedge ref_clk_i);
            instr_valid_i = (c == 4);
            instr_word_i  = (c == 4) ? w2 : ~w2; // Stale word must not be reused
            if (c == 2) chk_val(21'(busy_o), 21'(b));
            if (c == 9) chk_val(21'(busy_o), '0);
            if (stack_push_o === 1'b1) begin cy[0] = cy[0] ? 99 : c; vl[0] = stack_push_data_o; end
            if (pc_load_o === 1'b1) begin cy[1] = cy[1] ? 99 : c; vl[1] = pc_load_value_o; end
            if (mem_rd_o === 1'b1) begin cy[2] = cy[2] ? 99 : c; vl[2] = 21'(mem_rd_addr_o); end
            if (mem_wr_o === 1'b1) begin
                cy[3] = cy[3] ? 99 : c;
                vl[3] = {1'b0, mem_wr_addr_o, mem_wr_data_o};
            end
            if (illegal_dest_o === 1'b1) cy[4] = cy[4] ? 99 : c;
            if (stack_pop_o === 1'b1) cy[5] = cy[5] ? 99 : c;
            if (fp_load_o === 1'b1) begin cy[6] = cy[6] ? 99 : c; vl[6] = 21'(fp_value_o); end
        end
        for (int i = 0; i < 7; i++) begin
            chk_cyc(i, cy[i], ex_c[i]);
            if (ex_c[i] != 0) chk_val(vl[i], ex_v[i]);
        end
        ex_c = '{default: 0};
    endtask : run

    // Expected move traffic worked out from the offsets and frame pointer
    task automatic mv(input logic sel, input logic [11:0] f, input logic [6:0] zs,
                      input logic [11:0] dl, input logic [7:0] rd);
        logic [11:0] src;
        logic [11:0] dst;
        src = f + 12'(zs);
        dst = sel ? f + 12'(dl[6:0]) : dl;
        frame_pointer_reg_i = f;
        rd_data_i = rd;
        want(2, 3, 21'(src));
        if (f_ban(dst)) want(4, 7, '0);
        else if (!(sel && f_ind(dst))) want(3, 7, {1'b0, dst, f_ind(src) ? 8'h00 : rd});
        run({8'heb, sel, zs}, {4'hf, dl}, 1'b1);
    endtask : mv

    initial begin
        void'($urandom(3797));
        repeat (6) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        mv(0, 12'hfff, 7'h01, 12'h123, 8'h5a);
        mv(0, 12'hf80, 7'h6b, 12'h010, 8'h77);
        mv(0, 12'h100, 7'h7f, 12'hfeb, 8'h3c);
        mv(0, 12'h200, 7'h05, 12'hff9, 8'h11);
        mv(0, 12'h200, 7'h05, 12'hffd, 8'h11);
        mv(0, 12'h200, 7'h05, 12'hffe, 8'h11);
        mv(0, 12'h200, 7'h05, 12'hfff, 8'h11);
        mv(1, 12'hff0, 7'h00, 12'hf09, 8'h22);
        mv(1, 12'hfd0, 7'h01, 12'h00b, 8'h33);
        mv(1, 12'hf90, 7'h7f, 12'hfff, 8'h44);
        run({4'hf, 12'h123}, 16'hf000, 1'b0);
        run(16'h0015, 16'he9c5, 1'b0);
        // Enable low must freeze the phase one clock past the Q1 edge
        clk_en_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        chk_val(21'(phase_o), 21'(PH_Q2));
        chk_val(21'(busy_o), '0);
        clk_en_i = 1'b1;
        repeat (12) begin
            pc_i = 21'($urandom);
            working_register_i = 8'($urandom);
            pc_high_latch_i = 8'($urandom);
            pc_upper_latch_i = 8'($urandom);
            want(0, 3, pc_i + 21'h2);
            want(1, 4, {pc_upper_latch_i[4:0], pc_high_latch_i, working_register_i});
            run(16'h0014, 16'($urandom), 1'b1);
            fp = 12'($urandom);
            return_stack_top_i = 21'($urandom);
            frame_pointer_reg_i = fp;
            working_register_i = 8'($urandom);
            want(6, 4, 21'(12'(fp + 12'(working_register_i[5:0]))));
            want(1, 4, return_stack_top_i);
            want(5, 4, '0);
            run({10'h3a3, working_register_i[5:0]}, 16'($urandom), 1'b1);
            mv(1'($urandom), 12'($urandom), 7'($urandom), 12'($urandom), 8'($urandom));
        end
        report_and_stop();
    end
endmodule : emce_exec_bench
